// File: design/idau_core.sv
// indirect data address unit: pointer pairs, virtual operands, address forming
// assumes the core issues one data access per request and memory reads combinationally
`timescale 1ns/100ps

// Operation
// - three 12-bit pointer pairs from two bytes
// - plain operand accesses pointed location, no storage
// - indirect address ignores bank and access bit
// - post-decrement: use pointer, then subtract one
// - post-increment: use pointer, then add one
// - pre-increment: add one, then use it
// - plus-W: pointer plus signed working register
// - plain and plus-W leave pointer, W untouched
// - updates carry across whole 12-bit pair
// - pointer updates never touch status flags
// - indirect read of virtual operand gives zero
// - indirect write of virtual operand does nothing
// - write onto pointer: store, no auto-update
// - pointer bytes directly readable and writable
// - extended set leaves program memory alone
// - extended set keeps pointer zero/one, map
// - indexed offset only with config bit one
// - indexed when access bit zero, field <=5F
// - indexed address is pointer two plus field
// - inherent and literal instructions unaffected
// - access bit one: bank register plus field
// - extended, field >=60: upper special region
module idau_core #(
  parameter int PTR_COUNT = idau_pkg::NUM_PTR
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_access_bit,
  input wire logic [7:0] req_file_field,
  input wire logic req_long,
  input wire logic [11:0] req_long_addr,
  input wire logic [7:0] req_wdata,
  input wire logic [7:0] bank_select_register,
  input wire logic [7:0] working_reg,
  input wire logic extended_set_config_bit,
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic [11:0] pointer_zero,
  output logic [11:0] pointer_one,
  output logic [11:0] pointer_two
);

  if (PTR_COUNT != 3)
  begin : g_bad_count
    $error("idau_core serves exactly three pointer pairs");
  end

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [11:0] oper_base(input int i);
    begin
      unique case (i)
        0: oper_base = idau_pkg::OPER_BASE_0;
        1: oper_base = idau_pkg::OPER_BASE_1;
        default: oper_base = idau_pkg::OPER_BASE_2;
      endcase
    end
  endfunction

  function automatic logic [11:0] sext8(input logic [7:0] v);
    begin
      sext8 = {{4{v[7]}}, v};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  logic [11:0] ptr_ff [PTR_COUNT];
  logic [11:0] mem_addr_ff;
  logic mem_rd_ff;
  logic mem_wr_ff;
  logic [7:0] mem_wdata_ff;
  logic pend_rd_ff;
  logic pend_local_ff;
  logic [7:0] pend_data_ff;
  logic rsp_valid_ff;
  logic [7:0] rsp_data_ff;

  logic ilo;
  logic [11:0] ea;
  logic ind_hit;
  int ind_idx;
  idau_pkg::idau_op_t ind_op;
  logic [11:0] old_ptr;
  logic [11:0] tgt;
  logic tgt_virt;
  logic tgt_preg;
  int preg_idx;
  logic preg_high;
  logic upd_en;
  logic [11:0] nxt_ptr;
  logic wr_ptr_en;
  logic do_mem;
  logic [7:0] local_data;

  logic fire;
  assign fire = req_valid;

  always_comb
  begin
    ilo = 1'b0;
    ea = idau_pkg::PTR_RESET;
    ind_hit = 1'b0;
    ind_idx = 0;
    ind_op = idau_pkg::IDAU_OP_PLAIN;
    old_ptr = idau_pkg::PTR_RESET;
    tgt = idau_pkg::PTR_RESET;
    tgt_virt = 1'b0;
    tgt_preg = 1'b0;
    preg_idx = 0;
    preg_high = 1'b0;
    // only data-addressing requests arrive here; fetch path never passes through
    ilo = extended_set_config_bit && !req_long && !req_access_bit
          && (req_file_field <= idau_pkg::ILO_LIMIT);
    if (req_long)
      ea = req_long_addr;
    else if (req_access_bit)
      ea = {bank_select_register[3:0], req_file_field};
    else if (ilo)
      ea = ptr_ff[2] + {4'h0, req_file_field};
    else if (req_file_field >= idau_pkg::ACCESS_SPLIT)
      ea = {idau_pkg::ACCESS_HIGH_BANK, req_file_field};
    else
      ea = {idau_pkg::ACCESS_LOW_BANK, req_file_field};
    for (int i = 0; i < PTR_COUNT; i++)
    begin
      if (ea == oper_base(i) - idau_pkg::OFS_PLAIN)
      begin
        ind_hit = 1'b1;
        ind_idx = i;
        ind_op = idau_pkg::IDAU_OP_PLAIN;
      end
      if (ea == oper_base(i) - idau_pkg::OFS_AFTER_ACCESS_INCREMENT_OPERAND)
      begin
        ind_hit = 1'b1;
        ind_idx = i;
        ind_op = idau_pkg::IDAU_OP_AFTER_ACCESS_INCREMENT_OPERAND;
      end
      if (ea == oper_base(i) - idau_pkg::OFS_AFTER_ACCESS_DECREMENT_OPERAND)
      begin
        ind_hit = 1'b1;
        ind_idx = i;
        ind_op = idau_pkg::IDAU_OP_AFTER_ACCESS_DECREMENT_OPERAND;
      end
      if (ea == oper_base(i) - idau_pkg::OFS_BEFORE_ACCESS_INCREMENT_OPERAND)
      begin
        ind_hit = 1'b1;
        ind_idx = i;
        ind_op = idau_pkg::IDAU_OP_BEFORE_ACCESS_INCREMENT_OPERAND;
      end
      if (ea == oper_base(i) - idau_pkg::OFS_POINTER_PLUS_WORKING_OPERAND)
      begin
        ind_hit = 1'b1;
        ind_idx = i;
        ind_op = idau_pkg::IDAU_OP_POINTER_PLUS_WORKING_OPERAND;
      end
    end
    old_ptr = ptr_ff[ind_idx];
    // the pointer, plus one or W in pre-increment and plus-W, forms the address, no bank or access bit involved
    if (ind_hit)
    begin
      unique case (ind_op)
        idau_pkg::IDAU_OP_BEFORE_ACCESS_INCREMENT_OPERAND: tgt = old_ptr + idau_pkg::PTR_STEP;
        idau_pkg::IDAU_OP_POINTER_PLUS_WORKING_OPERAND: tgt = old_ptr + sext8(working_reg);
        default: tgt = old_ptr;
      endcase
    end
    else
      tgt = ea;
    for (int i = 0; i < PTR_COUNT; i++)
    begin
      if (ind_hit && (tgt <= oper_base(i)) && (tgt >= oper_base(i) - idau_pkg::OFS_POINTER_PLUS_WORKING_OPERAND))
        tgt_virt = 1'b1;
      if (tgt == oper_base(i) - idau_pkg::OFS_HIGH)
      begin
        tgt_preg = 1'b1;
        preg_idx = i;
        preg_high = 1'b1;
      end
      if (tgt == oper_base(i) - idau_pkg::OFS_LOW)
      begin
        tgt_preg = 1'b1;
        preg_idx = i;
        preg_high = 1'b0;
      end
    end
  end

  // direct access to an operand address goes through its pointer, never to that address itself
  always_comb
  begin
    wr_ptr_en = fire && req_write && tgt_preg && !tgt_virt;
    do_mem = fire && !tgt_virt && !tgt_preg;
    local_data = idau_pkg::READ_ZERO;
    if (tgt_preg && !tgt_virt)
      local_data = preg_high ? {4'h0, ptr_ff[preg_idx][11:8]}
                             : ptr_ff[preg_idx][7:0];
    // a nop write leaves the pointer alone; a write onto a pointer suppresses the step
    upd_en = fire && ind_hit && !(req_write && (tgt_virt || tgt_preg))
             && (ind_op inside {idau_pkg::IDAU_OP_AFTER_ACCESS_INCREMENT_OPERAND, idau_pkg::IDAU_OP_AFTER_ACCESS_DECREMENT_OPERAND,
                                idau_pkg::IDAU_OP_BEFORE_ACCESS_INCREMENT_OPERAND});
    // full-width add keeps carry and borrow in the pair; no flag output exists
    nxt_ptr = (ind_op == idau_pkg::IDAU_OP_AFTER_ACCESS_DECREMENT_OPERAND) ? old_ptr - idau_pkg::PTR_STEP
                                                    : old_ptr + idau_pkg::PTR_STEP;
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < PTR_COUNT; i++)
        ptr_ff[i] <= idau_pkg::PTR_RESET;
    end
    else
    begin
      for (int i = 0; i < PTR_COUNT; i++)
      begin
        if (wr_ptr_en && preg_idx == i)
        begin
          if (preg_high)
            ptr_ff[i][11:8] <= req_wdata[3:0];
          else
            ptr_ff[i][7:0] <= req_wdata;
        end
        else if (upd_en && ind_idx == i)
          ptr_ff[i] <= nxt_ptr;
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mem_addr_ff <= idau_pkg::PTR_RESET;
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      mem_wdata_ff <= 8'h00;
      pend_rd_ff <= 1'b0;
      pend_local_ff <= 1'b0;
      pend_data_ff <= 8'h00;
    end
    else
    begin
      mem_rd_ff <= do_mem && !req_write;
      mem_wr_ff <= do_mem && req_write;
      pend_rd_ff <= fire && !req_write;
      pend_local_ff <= !do_mem;
      if (fire)
      begin
        mem_addr_ff <= tgt;
        mem_wdata_ff <= req_wdata;
        pend_data_ff <= local_data;
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 8'h00;
    end
    else
    begin
      rsp_valid_ff <= pend_rd_ff;
      if (pend_rd_ff)
        rsp_data_ff <= pend_local_ff ? pend_data_ff : mem_rdata;
    end
  end

  assign mem_addr = mem_addr_ff;
  assign mem_rd = mem_rd_ff;
  assign mem_wr = mem_wr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign pointer_zero = ptr_ff[0];
  assign pointer_one = ptr_ff[1];
  assign pointer_two = ptr_ff[2];

  ////////////////////////////////////////////////////////////////////////////
  // checks; helper state records the request of the previous cycle

  logic [1:0] chk_idx_ff;
  logic [11:0] chk_old_ff;
  logic [11:0] chk_p2_ff;
  logic [7:0] chk_w_ff;
  logic [7:0] chk_f_ff;
  logic [3:0] chk_bank_ff;
  idau_pkg::idau_op_t chk_op_ff;
  logic chk_ind_ff;
  logic chk_upd_ff;
  logic chk_mem_ff;
  logic chk_ilo_ff;
  logic chk_dir_ff;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      chk_idx_ff <= 2'h0;
      chk_old_ff <= 12'h000;
      chk_p2_ff <= 12'h000;
      chk_w_ff <= 8'h00;
      chk_f_ff <= 8'h00;
      chk_bank_ff <= 4'h0;
      chk_op_ff <= idau_pkg::IDAU_OP_PLAIN;
      chk_ind_ff <= 1'b0;
      chk_upd_ff <= 1'b0;
      chk_mem_ff <= 1'b0;
      chk_ilo_ff <= 1'b0;
      chk_dir_ff <= 1'b0;
    end
    else
    begin
      chk_idx_ff <= 2'(ind_idx);
      chk_old_ff <= old_ptr;
      chk_p2_ff <= ptr_ff[2];
      chk_w_ff <= working_reg;
      chk_f_ff <= req_file_field;
      chk_bank_ff <= bank_select_register[3:0];
      chk_op_ff <= ind_op;
      chk_ind_ff <= fire && ind_hit && !wr_ptr_en;
      chk_upd_ff <= upd_en;
      chk_mem_ff <= do_mem;
      chk_ilo_ff <= fire && ilo && !ind_hit;
      chk_dir_ff <= fire && !req_long && req_access_bit && !ind_hit;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_after_access_decrement_operand;
    chk_upd_ff && chk_op_ff == idau_pkg::IDAU_OP_AFTER_ACCESS_DECREMENT_OPERAND
      |-> ptr_ff[chk_idx_ff] == chk_old_ff - 12'h001 && (!chk_mem_ff || mem_addr_ff == chk_old_ff);
  endproperty
  a_after_access_decrement_operand: assert property (p_after_access_decrement_operand) else $error("post-decrement wrong");

  property p_after_access_increment_operand;
    chk_upd_ff && chk_op_ff == idau_pkg::IDAU_OP_AFTER_ACCESS_INCREMENT_OPERAND
      |-> ptr_ff[chk_idx_ff] == chk_old_ff + 12'h001 && (!chk_mem_ff || mem_addr_ff == chk_old_ff);
  endproperty
  a_after_access_increment_operand: assert property (p_after_access_increment_operand) else $error("post-increment wrong");

  property p_before_access_increment_operand;
    chk_ind_ff && chk_mem_ff && chk_op_ff == idau_pkg::IDAU_OP_BEFORE_ACCESS_INCREMENT_OPERAND
      |-> mem_addr_ff == chk_old_ff + 12'h001 && ptr_ff[chk_idx_ff] == mem_addr_ff;
  endproperty
  a_before_access_increment_operand: assert property (p_before_access_increment_operand) else $error("pre-increment wrong");

  property p_pointer_plus_working_operand;
    chk_ind_ff && chk_mem_ff && chk_op_ff == idau_pkg::IDAU_OP_POINTER_PLUS_WORKING_OPERAND
      |-> mem_addr_ff == chk_old_ff + sext8(chk_w_ff) && ptr_ff[chk_idx_ff] == chk_old_ff;
  endproperty
  a_pointer_plus_working_operand: assert property (p_pointer_plus_working_operand) else $error("plus-W address wrong");

  property p_plain_keep;
    chk_ind_ff && chk_op_ff == idau_pkg::IDAU_OP_PLAIN
      |-> ptr_ff[chk_idx_ff] == chk_old_ff && (!chk_mem_ff || mem_addr_ff == chk_old_ff);
  endproperty
  a_plain_keep: assert property (p_plain_keep) else $error("plain operand moved pointer");

  property p_virt_read_zero;
    fire && !req_write && tgt_virt |-> ##1 !mem_rd ##1 rsp_valid && rsp_data == 8'h00;
  endproperty
  a_virt_read_zero: assert property (p_virt_read_zero) else $error("virtual read not zero");

  property p_virt_write_nop;
    fire && req_write && tgt_virt |=> !mem_wr && $stable(pointer_zero)
      && $stable(pointer_one) && $stable(pointer_two);
  endproperty
  a_virt_write_nop: assert property (p_virt_write_nop) else $error("virtual write acted");

  property p_indexed;
    chk_ilo_ff && chk_mem_ff |-> mem_addr_ff == chk_p2_ff + {4'h0, chk_f_ff};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_banked;
    chk_dir_ff && chk_mem_ff |-> mem_addr_ff == {chk_bank_ff, chk_f_ff};
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");

  // with the set off a low access-bank field must land in bank zero, never in the window
  property p_no_ilo_off;
    fire && !extended_set_config_bit && !req_long && !req_access_bit
      && req_file_field <= idau_pkg::ILO_LIMIT
      |=> mem_addr_ff == {idau_pkg::ACCESS_LOW_BANK, $past(req_file_field)};
  endproperty
  a_no_ilo_off: assert property (p_no_ilo_off) else $error("indexed mode while off");

  c_after_access_increment_operand_carry: cover property (chk_upd_ff && chk_old_ff[7:0] == 8'hFF
                                   && chk_op_ff == idau_pkg::IDAU_OP_AFTER_ACCESS_INCREMENT_OPERAND);
  c_indexed: cover property (chk_ilo_ff && chk_mem_ff);
  c_virt_read: cover property (fire && !req_write && tgt_virt ##2 rsp_valid);
  c_ptr_write_ind: cover property (fire && req_write && ind_hit && tgt_preg);

endmodule

// File: design/idau_pkg.sv
// constants shared by the indirect data address unit
// assumes a 12-bit data space and three pointer pairs
package idau_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int NUM_PTR = 3;

  // top of each pointer's five-address operand block
  localparam logic [11:0] OPER_BASE_0 = 12'hFEF;
  // pointer_one_virtual_operand
  localparam logic [11:0] OPER_BASE_1 = 12'hFE7;
  localparam logic [11:0] OPER_BASE_2 = 12'hFDF;

  // distance below the block top
  localparam logic [11:0] OFS_PLAIN = 12'h000;
  localparam logic [11:0] OFS_AFTER_ACCESS_INCREMENT_OPERAND = 12'h001;
  localparam logic [11:0] OFS_AFTER_ACCESS_DECREMENT_OPERAND = 12'h002;
  localparam logic [11:0] OFS_BEFORE_ACCESS_INCREMENT_OPERAND = 12'h003;
  localparam logic [11:0] OFS_POINTER_PLUS_WORKING_OPERAND = 12'h004;
  localparam logic [11:0] OFS_HIGH = 12'h005;
  localparam logic [11:0] OFS_LOW = 12'h006;

  localparam logic [7:0] ILO_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [11:0] PTR_RESET = 12'h000;
  localparam logic [11:0] PTR_STEP = 12'h001;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef enum logic [4:0] {
    IDAU_OP_PLAIN = 5'h01,
    IDAU_OP_AFTER_ACCESS_INCREMENT_OPERAND = 5'h02,
    IDAU_OP_AFTER_ACCESS_DECREMENT_OPERAND = 5'h04,
    IDAU_OP_BEFORE_ACCESS_INCREMENT_OPERAND = 5'h08,
    IDAU_OP_POINTER_PLUS_WORKING_OPERAND = 5'h10
  } idau_op_t;

endpackage

// File: tb/idau_core_bench.sv
// self-checking bench for the indirect data address unit
// assumes the memory model answers reads combinationally
`timescale 1ns/100ps
module idau_core_bench;
  logic clock, rst, req_valid, req_write, req_access_bit, req_long;
  logic [7:0] req_file_field, req_wdata, bank_select_register, working_reg, mem_rdata;
  logic [11:0] req_long_addr, mem_addr, pointer_zero, pointer_one, pointer_two;
  logic extended_set_config_bit, mem_rd, mem_wr, rsp_valid;
  logic [7:0] mem_wdata, rsp_data;
  int bad_count, check_count, cycle_count;

  idau_core dut_u (
    .clock(clock), .rst(rst), .req_valid(req_valid), .req_write(req_write),
    .req_access_bit(req_access_bit), .req_file_field(req_file_field),
    .req_long(req_long), .req_long_addr(req_long_addr), .req_wdata(req_wdata),
    .bank_select_register(bank_select_register), .working_reg(working_reg),
    .extended_set_config_bit(extended_set_config_bit), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pointer_zero(pointer_zero),
    .pointer_one(pointer_one), .pointer_two(pointer_two)
  );

  idau_mem_model mem_u (
    .clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ a[11:4];
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  // one request; strobe checked in the next cycle, read answer one later
  task automatic xfer(input logic w, input logic a, input logic [7:0] f, input logic [7:0] d,
    input logic strobe, input logic [11:0] addr, input logic [7:0] rdat);
    @(negedge clock);
    req_valid = 1'b1;
    req_write = w;
    req_access_bit = a;
    req_file_field = f;
    req_wdata = d;
    @(negedge clock);
    req_valid = 1'b0;
    chk("strobe", 12'(strobe), 12'(w ? mem_wr : mem_rd));
    if (strobe)
      chk("mem_addr", addr, mem_addr);
    if (strobe && w)
      chk("mem_wdata", 12'(d), 12'(mem_wdata));
    @(negedge clock);
    if (!w)
    begin
      chk("rsp_valid", 12'h001, 12'(rsp_valid));
      chk("rsp_data", 12'(rdat), 12'(rsp_data));
    end
  endtask

  // pointer bytes sit at block top minus 6 and 5; junk upper nibble on purpose
  task automatic setp(input int n, input logic [11:0] v);
    logic [7:0] lo;
    lo = 8'hE9 - 8'(8 * n);
    xfer(1'b1, 1'b0, lo, v[7:0], 1'b0, 12'h000, 8'h00);
    xfer(1'b1, 1'b0, lo + 8'h01, {4'hF, v[11:8]}, 1'b0, 12'h000, 8'h00);
  endtask

  always @(posedge clock)
  begin
    cycle_count++;
    if (cycle_count == 2000)
    begin
      bad_count++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] wv [3];
    wv = '{8'hFE, 8'h7F, 8'h80};
    bad_count = 0;
    check_count = 0;
    cycle_count = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_access_bit = 1'b0;
    req_file_field = 8'h00;
    req_wdata = 8'h00;
    req_long = 1'b0;
    req_long_addr = 12'h000;
    bank_select_register = 8'h00;
    working_reg = 8'h00;
    extended_set_config_bit = 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    chk("pointer_zero", 12'h000, pointer_zero);
    chk("pointer_two", 12'h000, pointer_two);
    $display("test reset done");

    setp(0, 12'h0FF);
    chk("pointer_zero", 12'h0FF, pointer_zero);
    xfer(1'b0, 1'b0, 8'hEE, 8'h00, 1'b1, 12'h0FF, pat(12'h0FF));
    chk("pointer_zero", 12'h100, pointer_zero);
    xfer(1'b0, 1'b0, 8'hEA, 8'h00, 1'b0, 12'h000, 8'h01);
    xfer(1'b0, 1'b0, 8'hED, 8'h00, 1'b1, 12'h100, pat(12'h100));
    chk("pointer_zero", 12'h0FF, pointer_zero);
    xfer(1'b0, 1'b0, 8'hEC, 8'h00, 1'b1, 12'h100, pat(12'h100));
    chk("pointer_zero", 12'h100, pointer_zero);
    $display("test auto update done");

    bank_select_register = 8'h0F;
    xfer(1'b1, 1'b1, 8'hEF, 8'hA5, 1'b1, 12'h100, 8'h00);
    bank_select_register = 8'h03;
    xfer(1'b0, 1'b0, 8'hEF, 8'h00, 1'b1, 12'h100, 8'hA5);
    chk("pointer_zero", 12'h100, pointer_zero);
    foreach (wv[i])
    begin
      working_reg = wv[i];
      xfer(1'b0, 1'b0, 8'hEB, 8'h00, 1'b1, 12'h100 + {{4{wv[i][7]}}, wv[i]},
        pat(12'h100 + {{4{wv[i][7]}}, wv[i]}));
      chk("pointer_zero", 12'h100, pointer_zero);
    end
    $display("test plain and plus-w done");

    setp(0, 12'hFE7);
    xfer(1'b0, 1'b0, 8'hEF, 8'h00, 1'b0, 12'h000, 8'h00);
    xfer(1'b1, 1'b0, 8'hEF, 8'h55, 1'b0, 12'h000, 8'h00);
    chk("pointer_one", 12'h000, pointer_one);
    setp(0, 12'hFE1);
    xfer(1'b1, 1'b0, 8'hEE, 8'h34, 1'b0, 12'h000, 8'h00);
    chk("pointer_one", 12'h034, pointer_one);
    chk("pointer_zero", 12'hFE1, pointer_zero);
    $display("test pointer on pointer done");

    setp(2, 12'h200);
    chk("pointer_two", 12'h200, pointer_two);
    extended_set_config_bit = 1'b1;
    xfer(1'b0, 1'b0, 8'h10, 8'h00, 1'b1, 12'h210, pat(12'h210));
    xfer(1'b0, 1'b0, 8'h5F, 8'h00, 1'b1, 12'h25F, pat(12'h25F));
    xfer(1'b0, 1'b0, 8'h60, 8'h00, 1'b1, 12'hF60, pat(12'hF60));
    bank_select_register = 8'h05;
    xfer(1'b0, 1'b1, 8'h10, 8'h00, 1'b1, 12'h510, pat(12'h510));
    setp(0, 12'h300);
    xfer(1'b0, 1'b0, 8'hEE, 8'h00, 1'b1, 12'h300, pat(12'h300));
    chk("pointer_zero", 12'h301, pointer_zero);
    // full address in the opcode bypasses the indexed window
    req_long = 1'b1;
    req_long_addr = 12'h123;
    xfer(1'b0, 1'b0, 8'h10, 8'h00, 1'b1, 12'h123, pat(12'h123));
    req_long = 1'b0;
    extended_set_config_bit = 1'b0;
    xfer(1'b0, 1'b0, 8'h10, 8'h00, 1'b1, 12'h010, pat(12'h010));
    $display("test extended mode done");
    final_report();
  end
endmodule

// File: tb/idau_mem_model.sv
// data memory array model on the far side of the address unit
// assumes reads are answered combinationally while the read strobe is high
`timescale 1ns/100ps
module idau_mem_model (
  input wire logic clock,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] store [4096];
  logic [7:0] last_ff;

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < 4096; i++)
    begin
      store[i] = 8'(i) ^ 8'(i >> 4);
    end
    last_ff = 8'h00;
  end

  always @(posedge clock)
  begin
    if (mem_wr)
    begin
      store[mem_addr] <= mem_wdata;
    end
    if (mem_rd)
    begin
      last_ff <= store[mem_addr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // off-strobe data is inverted so a stale value never looks right
  assign mem_rdata = mem_rd ? store[mem_addr] : ~last_ff;
endmodule
